// >>> hdl/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define DCC_OFF_CONFIG    12'h000
`define DCC_OFF_STATUS    12'h004
`define DCC_OFF_OFS_A     12'h008
`define DCC_OFF_OFS_B     12'h00c
`define DCC_BASE_INPUT    12'h100
`define DCC_BASE_DATA     12'h140
`define DCC_BASE_GAIN     12'h180
`define DCC_BASE_ZERO     12'h1c0
`define DCC_BANK_MASK     12'hfc0
`define DCC_CH_LSB        2

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define DCC_CFG_CE_BIT    0
`define DCC_CFG_GAIN_BIT  1
`define DCC_CODE_W        14
`define DCC_GAIN_RST      14'h2000
`define DCC_ZERO_RST      14'h0000
`define DCC_INPUT_RST     14'h0000
`define DCC_MSB_FLIP      14'h2000
`define DCC_CODE_MAX      14'h3fff
`define DCC_OFS_G6_RST    14'h2666
`define DCC_OFS_G4_RST    14'h2aab
`define DCC_GAIN_SHIFT    14
`define DCC_GAIN_BIAS     32'h00002000

`endif

// >>> hdl/dcc_pkg.sv
package dcc_pkg;
  typedef logic [13:0] dcc_code_t;
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_CALC = 2'b01,
    DCC_DONE = 2'b11
  } dcc_state_e;
endpackage : dcc_pkg

// >>> hdl/dcc_engine.sv
`timescale 1ns/100ps
`include "dcc_cfg.svh"

module dcc_engine
  import dcc_pkg::*;
(
  // clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // operands
  input  wire logic      start,
  input  wire dcc_code_t raw_code,
  input  wire dcc_code_t gain_code,
  input  wire dcc_code_t zero_code,
  // result
  output logic           done,
  output dcc_code_t      result
);

  logic signed [31:0] prod;
  logic signed [31:0] sum;
  dcc_code_t          next_result;
  logic               next_done;

  always_comb begin
    prod = $signed({18'h00000, raw_code})
         * $signed({18'h00000, gain_code} + `DCC_GAIN_BIAS);
    sum  = (prod >>> `DCC_GAIN_SHIFT)
         + $signed({{18{zero_code[13]}}, zero_code});
    if (sum < 0) begin
      next_result = 14'h0000;
    end else if (sum > $signed({18'h00000, `DCC_CODE_MAX})) begin
      next_result = `DCC_CODE_MAX;
    end else begin
      next_result = sum[13:0];
    end
    next_done = start;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 14'h0000;
      done   <= 1'b0;
    end else begin
      if (start) begin
        result <= next_result;
      end
      done <= next_done;
    end
  end

endmodule : dcc_engine

// >>> hdl/dcc_top.sv
// Notes on behaviour
// - per channel gain, zero, input, data registers
// - enabled input, gain, zero writes recompute and store corrected code
// - code times (gain plus 8192) over 16384 plus zero
// - gain 0.5 to 1.5, zero signed
// - one shared engine, channels served in turn
// - enable bit one turns engine on
// - disabled: data direct, cal writes only store
// - gain and zero read back as written
// - raw from input when enabled, else data
// - gain select bit, four or six
// - offset default per gain setting
// - reset gain 8192, zero 0, input 0
// - strap low binary, high twos complement
// - twos complement means top bit inverted
// - gain always binary, zero always twos complement
// - readback in written coding
// - gain change reloads offset defaults
`timescale 1ns/100ps
`include "dcc_cfg.svh"

module dcc_top
  import dcc_pkg::*;
#(
  parameter int NCH = 8
)
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // strap
  input  wire logic        data_format_strap,
  // converter side
  output logic             load_strobe,
  output logic [2:0]       load_channel,
  output dcc_code_t        load_code,
  output dcc_code_t        group_offset_code_a,
  output dcc_code_t        group_offset_code_b,
  output logic             gain_six
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  dcc_code_t  input_reg [NCH];
  dcc_code_t  data_reg  [NCH];
  dcc_code_t  gain_reg  [NCH];
  dcc_code_t  zero_reg  [NCH];
  logic [NCH-1:0] pend;
  logic       correction_enable;
  dcc_code_t  ofs_a;
  dcc_code_t  ofs_b;
  dcc_state_e state;
  logic [2:0] cur_ch;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic [2:0] ch;
  logic       bank_in;
  logic       bank_dat;
  logic       bank_gn;
  logic       bank_zr;
  logic       mapped;

  always_comb begin
    acc      = psel && penable && pready;
    ch       = paddr[`DCC_CH_LSB +: 3];
    bank_in  = (paddr & `DCC_BANK_MASK) == `DCC_BASE_INPUT;
    bank_dat = (paddr & `DCC_BANK_MASK) == `DCC_BASE_DATA;
    bank_gn  = (paddr & `DCC_BANK_MASK) == `DCC_BASE_GAIN;
    bank_zr  = (paddr & `DCC_BANK_MASK) == `DCC_BASE_ZERO;
    mapped   = ((bank_in || bank_dat || bank_gn || bank_zr)
                && paddr[5] == 1'b0 && paddr[1:0] == 2'b00)
             || paddr == `DCC_OFF_CONFIG || paddr == `DCC_OFF_STATUS
             || paddr == `DCC_OFF_OFS_A || paddr == `DCC_OFF_OFS_B;
    wr       = acc && pwrite && mapped;
  end

  // coding helpers: strap selects msb flip on channel/offset codes
  function automatic dcc_code_t to_bin(input dcc_code_t c,
                                       input logic f);
    to_bin = f ? (c ^ `DCC_MSB_FLIP) : c;
  endfunction : to_bin

  // ----------------------------------------------------------------
  // correction sequencer
  // ----------------------------------------------------------------
  dcc_state_e next_state;
  logic [2:0] next_cur_ch;
  logic [NCH-1:0] next_pend;
  logic       eng_start;
  logic       eng_done;
  dcc_code_t  eng_result;
  logic [2:0] pick;
  logic       any;

  always_comb begin
    pick = 3'd0;
    any  = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 3'(i);
        any  = 1'b1;
      end
    end
    next_state  = state;
    next_cur_ch = cur_ch;
    next_pend   = pend;
    eng_start   = 1'b0;
    case (state)
      DCC_IDLE: begin
        if (any && correction_enable) begin
          next_cur_ch     = pick;
          next_pend[pick] = 1'b0;
          eng_start       = 1'b1;
          next_state      = DCC_CALC;
        end
      end
      DCC_CALC: begin
        next_state = DCC_DONE;
      end
      DCC_DONE: begin
        next_state = DCC_IDLE;
      end
      default: begin
        next_state = DCC_IDLE;
      end
    endcase
    if (!correction_enable) begin
      next_pend = '0;
    end
    // set wins over clear
    if (wr && correction_enable && (bank_in || bank_gn || bank_zr)
        && paddr[5] == 1'b0) begin
      next_pend[ch] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= DCC_IDLE;
      cur_ch <= 3'd0;
      pend   <= '0;
    end else begin
      state  <= next_state;
      cur_ch <= next_cur_ch;
      pend   <= next_pend;
    end
  end

  dcc_engine dcc_engine_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (eng_start),
    .raw_code  (to_bin(input_reg[next_cur_ch], data_format_strap)),
    .gain_code (gain_reg[next_cur_ch]),
    .zero_code (zero_reg[next_cur_ch]),
    .done      (eng_done),
    .result    (eng_result)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  logic next_gain_six;

  always_comb begin
    next_gain_six = gain_six;
    if (wr && paddr == `DCC_OFF_CONFIG) begin
      next_gain_six = pwdata[`DCC_CFG_GAIN_BIT];
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          input_reg[g] <= `DCC_INPUT_RST;
          gain_reg[g]  <= `DCC_GAIN_RST;
          zero_reg[g]  <= `DCC_ZERO_RST;
          data_reg[g]  <= `DCC_INPUT_RST;
        end else begin
          if (wr && bank_in && ch == 3'(g)) begin
            input_reg[g] <= pwdata[13:0];
          end
          if (wr && bank_gn && ch == 3'(g)) begin
            gain_reg[g] <= pwdata[13:0];
          end
          if (wr && bank_zr && ch == 3'(g)) begin
            zero_reg[g] <= pwdata[13:0];
          end
          if (wr && bank_dat && ch == 3'(g)) begin
            data_reg[g] <= pwdata[13:0];
          end else if (eng_done && cur_ch == 3'(g)) begin
            data_reg[g] <= to_bin(eng_result, data_format_strap);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      correction_enable <= 1'b1;
      gain_six          <= 1'b1;
      ofs_a             <= `DCC_OFS_G6_RST;
      ofs_b             <= `DCC_OFS_G6_RST;
    end else begin
      gain_six <= next_gain_six;
      if (wr && paddr == `DCC_OFF_CONFIG) begin
        correction_enable <= pwdata[`DCC_CFG_CE_BIT];
      end
      if (next_gain_six != gain_six) begin
        ofs_a <= next_gain_six ? `DCC_OFS_G6_RST : `DCC_OFS_G4_RST;
        ofs_b <= next_gain_six ? `DCC_OFS_G6_RST : `DCC_OFS_G4_RST;
      end else begin
        if (wr && paddr == `DCC_OFF_OFS_A) begin
          ofs_a <= pwdata[13:0];
        end
        if (wr && paddr == `DCC_OFF_OFS_B) begin
          ofs_b <= pwdata[13:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // converter side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_strobe         <= 1'b0;
      load_channel        <= 3'd0;
      load_code           <= 14'h0000;
      group_offset_code_a <= 14'h0000;
      group_offset_code_b <= 14'h0000;
    end else begin
      load_strobe <= (wr && bank_dat && paddr[5] == 1'b0) || eng_done;
      if (wr && bank_dat && paddr[5] == 1'b0) begin
        load_channel <= ch;
        load_code    <= to_bin(pwdata[13:0], data_format_strap);
      end else if (eng_done) begin
        load_channel <= cur_ch;
        load_code    <= eng_result;
      end
      group_offset_code_a <= to_bin(ofs_a, data_format_strap);
      group_offset_code_b <= to_bin(ofs_b, data_format_strap);
    end
  end

  // ----------------------------------------------------------------
  // apb read and ready
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h00000000;
    if (!mapped) begin
      next_prdata = 32'h00000000;
    end else if (bank_in) begin
      next_prdata = {18'h00000, input_reg[ch]};
    end else if (bank_dat) begin
      next_prdata = {18'h00000, data_reg[ch]};
    end else if (bank_gn) begin
      next_prdata = {18'h00000, gain_reg[ch]};
    end else if (bank_zr) begin
      next_prdata = {18'h00000, zero_reg[ch]};
    end else if (paddr == `DCC_OFF_CONFIG) begin
      next_prdata = {30'h00000000, gain_six, correction_enable};
    end else if (paddr == `DCC_OFF_STATUS) begin
      next_prdata = {23'h000000, (state != DCC_IDLE), pend};
    end else if (paddr == `DCC_OFF_OFS_A) begin
      next_prdata = {18'h00000, ofs_a};
    end else if (paddr == `DCC_OFF_OFS_B) begin
      next_prdata = {18'h00000, ofs_b};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= next_prdata;
      pslverr <= psel && !penable && !mapped;
    end
  end

endmodule : dcc_top

// >>> verification/dcc_chk.sv
`timescale 1ns/100ps
// ----
// port checker
// ----
module dcc_chk
  import dcc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // strap
  input wire logic        data_format_strap,
  // converter side
  input wire logic        load_strobe,
  input wire logic [2:0]  load_channel,
  input wire dcc_code_t   load_code,
  input wire dcc_code_t   group_offset_code_a,
  input wire dcc_code_t   group_offset_code_b,
  input wire logic        gain_six
);
  logic acc;
  logic ce;
  logic next_ce;
  assign acc = psel && penable && pready && pwrite;
  always_comb begin
    next_ce = ce;
    if (acc && paddr == 12'h000) next_ce = pwdata[0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ce <= 1'b1;
    else ce <= next_ce;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  gain_sel_a: assert property (acc && paddr == 12'h000
    |=> gain_six == $past(pwdata[1])) else $error("gain select");
  cfg_read_a: assert property (psel && !penable && !pwrite
    && paddr == 12'h000 |=> pready && prdata[1:0] == {gain_six, ce})
    else $error("config readback");
  ofs_reload_a: assert property (!data_format_strap
    && $changed(gain_six) |=> group_offset_code_a == (gain_six ?
    14'h2666 : 14'h2aab) && group_offset_code_b == group_offset_code_a)
    else $error("offset reload");
  ofs_reset_a: assert property (!data_format_strap && $rose(presetn)
    |=> group_offset_code_a == 14'h2666) else $error("offset default");
  no_calc_a: assert property (acc && !ce && paddr[11:7] == 5'h03
    |=> !load_strobe [*4]) else $error("calc while disabled");
  recompute_a: assert property (acc && ce && paddr[11:6] == 6'h04
    |-> ##[1:40] load_strobe) else $error("no recompute");
  bypass_a: assert property (acc && !ce && paddr[11:6] == 6'h05
    |=> load_strobe && load_channel == $past(paddr[4:2]) && load_code ==
    ($past(pwdata[13:0]) ^ {data_format_strap, 13'h0000}))
    else $error("bypass load");
  one_engine_a: assert property (load_strobe
    |=> !load_strobe) else $error("strobe twice");
endmodule : dcc_chk

bind dcc_top dcc_chk dcc_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .data_format_strap(data_format_strap), .load_strobe(load_strobe),
  .load_channel(load_channel), .load_code(load_code),
  .group_offset_code_a(group_offset_code_a),
  .group_offset_code_b(group_offset_code_b), .gain_six(gain_six));

// >>> verification/dcc_conv_model.sv
`timescale 1ns/100ps
// ----
// converter latch model
// ----
module dcc_conv_model
  import dcc_pkg::*;
(
  // clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // load port
  input wire logic      load_strobe,
  input wire logic [2:0] load_channel,
  input wire dcc_code_t load_code
);
  dcc_code_t latch [8];
  int        loads;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) loads <= 0;
    else if (load_strobe === 1'b1) begin
      latch[load_channel] <= load_code;
      loads <= loads + 1;
    end
  end
endmodule : dcc_conv_model

// >>> verification/dcc_top_bench.sv
`timescale 1ns/100ps
// ----
// bench
// ----
module dcc_top_bench;
  import dcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, strap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, ls, g6, er;
  logic [2:0]  lch;
  dcc_code_t   lc, oa, ob;
  int          errors, checks;
  dcc_top dcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_format_strap(strap), .load_strobe(ls), .load_channel(lch),
    .load_code(lc), .group_offset_code_a(oa),
    .group_offset_code_b(ob), .gain_six(g6));
  dcc_conv_model dcc_conv_model_inst (.pclk(pclk), .presetn(presetn),
    .load_strobe(ls), .load_channel(lch), .load_code(lc));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : rw
  task wr(input logic [11:0] a, input logic [31:0] d);
    rw(1, a, d);
    repeat (8) @(posedge pclk);
  endtask : wr
  function logic [31:0] lat(input int c);
    return 32'(dcc_conv_model_inst.latch[c]);
  endfunction : lat
  task t_reset;
    rw(0, 12'h180, 0);
    chk(rd, 32'h2000);
    rw(0, 12'h1c0, 0);
    chk(rd, 32'h0);
    rw(0, 12'h11c, 0);
    chk(rd, 32'h0);
    rw(0, 12'h000, 0);
    chk(rd, 32'h3);
    chk(oa, 14'h2666);
    chk(g6, 1'b1);
    rw(0, 12'h0f0, 0);
    chk(er, 1'b1);
    rw(1, 12'h120, 32'h0555);
    chk(er, 1'b1);
    rw(0, 12'h100, 0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_corr;
    rw(1, 12'h104, 32'h1000);
    rw(0, 12'h004, 0);
    chk(rd, 32'h100);
    wr(12'h108, 32'h0123);
    chk(lat(1), 32'h1000);
    chk(lat(2), 32'h0123);
    rw(0, 12'h148, 0);
    chk(rd, 32'h0123);
    wr(12'h18c, 32'h3fff);
    wr(12'h10c, 32'h2000);
    chk(lat(3), 32'h2fff);
    wr(12'h1cc, 32'h3fff);
    chk(lat(3), 32'h2ffe);
    rw(0, 12'h18c, 0);
    chk(rd, 32'h3fff);
    wr(12'h10c, 32'h3fff);
    chk(lat(3), 32'h3fff);
    wr(12'h1cc, 32'h2000);
    wr(12'h10c, 0);
    chk(lat(3), 32'h0);
    $display("correction test done");
  endtask : t_corr
  task t_bypass;
    int n;
    wr(12'h000, 32'h2);
    n = dcc_conv_model_inst.loads;
    wr(12'h184, 32'h1234);
    chk(dcc_conv_model_inst.loads, n);
    rw(0, 12'h184, 0);
    chk(rd, 32'h1234);
    wr(12'h144, 32'h00ab);
    chk(lat(1), 32'h00ab);
    wr(12'h000, 32'h3);
    $display("bypass test done");
  endtask : t_bypass
  task t_strap;
    strap <= 1;
    wr(12'h110, 0);
    chk(lat(4), 32'h2000);
    rw(0, 12'h110, 0);
    chk(rd, 32'h0);
    wr(12'h110, 32'h3fff);
    chk(lat(4), 32'h1fff);
    wr(12'h190, 0);
    chk(lat(4), 32'h0fff);
    strap <= 0;
    $display("strap test done");
  endtask : t_strap
  task t_gain;
    wr(12'h000, 32'h1);
    chk(g6, 1'b0);
    chk(oa, 14'h2aab);
    chk(ob, 14'h2aab);
    wr(12'h000, 32'h3);
    chk(ob, 14'h2666);
    $display("gain test done");
  endtask : t_gain
  task summarize;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    summarize;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; strap = 0;
    paddr = 0; pwdata = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_corr;
    t_bypass;
    t_strap;
    t_gain;
    summarize;
  end
endmodule : dcc_top_bench
